// ===== hdl/addr_decode_pkg.sv
// constants for the system address decoder and its internal memory alias logic
// assumes a single 32-bit byte address bus shared by all bus masters
package addr_decode_pkg;
	localparam int addr_w = 32;
	localparam int area_msb = 31;
	localparam int area_lsb = 28;
	localparam int region_msb = 27;
	localparam int region_lsb = 20;
	localparam logic [3:0] area_internal = 4'h0;
	localparam logic [3:0] area_ext_first = 4'h1;
	localparam logic [3:0] area_ext_last = 4'h8;
	localparam logic [3:0] area_periph = 4'hF;
	localparam int ext_cs_count = 8;
	// 1-Mbyte regions inside area zero
	localparam logic [7:0] region_alias = 8'h00;
	localparam logic [7:0] region_flash = 8'h01;
	localparam logic [7:0] region_sram = 8'h02;
	localparam logic [7:0] region_rom = 8'h03;
	localparam int boot_select_bit_index = 2;
	localparam int sram_size_large = 32768;
	localparam int sram_size_small = 8192;
	localparam int flash_plane_size = 262144;
	localparam int flash_plane_bit = 18;
	localparam logic boot_select_reset = 1'b0;
	typedef enum logic [2:0] {tgt_none, tgt_internal, tgt_external, tgt_periph, tgt_abort} target_t;
	typedef enum logic [2:0] {mem_none, mem_flash0, mem_flash1, mem_sram, mem_rom} mem_t;
endpackage

// ===== hdl/area_split.sv
// first-stage split of a 32-bit address into one of sixteen 256-Mbyte areas
// assumes the address is stable for the cycle in which it is decoded
`timescale 1ns/1ps
module area_split (
	// address in
	input wire logic [31:0] addr,
	// area decode out
	output logic [3:0] area,
	output logic is_internal,
	output logic is_external,
	output logic is_periph,
	output logic [7:0] ext_sel
);
	always_comb begin
		area = addr[addr_decode_pkg::area_msb:addr_decode_pkg::area_lsb];
		is_internal = (area == addr_decode_pkg::area_internal);
		is_external = (area >= addr_decode_pkg::area_ext_first)
			&& (area <= addr_decode_pkg::area_ext_last);
		is_periph = (area == addr_decode_pkg::area_periph);
		ext_sel = 8'h00;
		for (int i = 0; i < addr_decode_pkg::ext_cs_count; i++) begin
			// area one lands on select zero
			if (is_external && (area == 4'(i + 1))) begin
				ext_sel[i] = 1'b1;
			end
		end
	end
endmodule

// ===== hdl/system_address_decoder_remap.sv
// system address decoder with remap and boot-select aliasing at address zero
// assumes one registered request per access; outputs follow one cycle after the request
`timescale 1ns/1ps
module system_address_decoder_remap #(
	parameter int sram_size = addr_decode_pkg::sram_size_large,
	parameter bit dual_plane = 1'b1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// master request
	input wire logic req_valid,
	input wire logic [31:0] req_addr,
	// remap and boot-select controls
	input wire logic remap_cmd,
	input wire logic nvm_set_cmd,
	input wire logic nvm_clear_cmd,
	input wire logic erase,
	// decode results
	output logic sel_valid,
	output logic [7:0] external_chip_select,
	output logic periph_sel,
	output logic internal_sel,
	output logic flash0_sel,
	output logic flash1_sel,
	output logic sram_sel,
	output logic rom_sel,
	output logic [31:0] mem_offset,
	output logic abort,
	// state visible to the system
	output logic remapped,
	output logic boot_select_nvm_bit
);
	localparam logic [31:0] sram_mask = 32'(sram_size - 1);
	localparam logic [31:0] plane_mask = 32'(addr_decode_pkg::flash_plane_size - 1);
	// offset masks follow the area and region field positions
	localparam logic [31:0] region_mask = 32'((1 << addr_decode_pkg::region_lsb) - 1);
	localparam logic [31:0] area_mask = 32'((1 << addr_decode_pkg::area_lsb) - 1);

	logic [3:0] area;
	logic is_internal;
	logic is_external;
	logic is_periph;
	logic [7:0] ext_sel;

	area_split u_area_split (
		.addr(req_addr),
		.area(area),
		.is_internal(is_internal),
		.is_external(is_external),
		.is_periph(is_periph),
		.ext_sel(ext_sel)
	);

	// remap and boot-select state
	logic next_remapped;
	logic next_boot_select_nvm_bit;

	always_comb begin
		next_remapped = remapped;
		if (remap_cmd) begin
			next_remapped = 1'b1;
		end
		next_boot_select_nvm_bit = boot_select_nvm_bit;
		// only the flash command strobes reach the bit; erase overrides both
		if (nvm_set_cmd) begin
			next_boot_select_nvm_bit = 1'b1;
		end else if (nvm_clear_cmd) begin
			next_boot_select_nvm_bit = 1'b0;
		end
		if (erase) begin
			next_boot_select_nvm_bit = 1'b0;
		end
	end

	// a real part keeps the bit across resets; here reset restores the default
	always_ff @(posedge core_clk) begin
		if (reset) begin
			remapped <= 1'b0;
			boot_select_nvm_bit <= addr_decode_pkg::boot_select_reset;
		end else begin
			remapped <= next_remapped;
			boot_select_nvm_bit <= next_boot_select_nvm_bit;
		end
	end

	// second stage inside area zero
	function automatic addr_decode_pkg::mem_t zero_alias(input logic rmp, input logic boot_bit);
		if (rmp) begin
			zero_alias = addr_decode_pkg::mem_sram;
		end else if (boot_bit) begin
			zero_alias = addr_decode_pkg::mem_flash0;
		end else begin
			zero_alias = addr_decode_pkg::mem_rom;
		end
	endfunction

	addr_decode_pkg::mem_t mem;
	addr_decode_pkg::target_t target;
	logic [7:0] region;
	logic [31:0] offset;

	always_comb begin
		region = req_addr[addr_decode_pkg::region_msb:addr_decode_pkg::region_lsb];
		offset = req_addr & region_mask;
		mem = addr_decode_pkg::mem_none;
		if (region == addr_decode_pkg::region_alias) begin
			mem = zero_alias(remapped, boot_select_nvm_bit);
		end else if (region == addr_decode_pkg::region_flash) begin
			mem = addr_decode_pkg::mem_flash0;
		end else if (region == addr_decode_pkg::region_sram) begin
			mem = addr_decode_pkg::mem_sram;
		end else if (region == addr_decode_pkg::region_rom) begin
			mem = addr_decode_pkg::mem_rom;
		end
		if (mem == addr_decode_pkg::mem_sram) begin
			offset = offset & sram_mask;
		end else if (mem == addr_decode_pkg::mem_flash0) begin
			// upper plane goes to the second controller so the planes run apart
			if (dual_plane && offset[addr_decode_pkg::flash_plane_bit]) begin
				mem = addr_decode_pkg::mem_flash1;
			end
			offset = offset & plane_mask;
		end
		if (is_internal) begin
			target = (mem == addr_decode_pkg::mem_none) ? addr_decode_pkg::tgt_abort
				: addr_decode_pkg::tgt_internal;
		end else if (is_external) begin
			target = addr_decode_pkg::tgt_external;
		end else if (is_periph) begin
			target = addr_decode_pkg::tgt_periph;
		end else begin
			target = addr_decode_pkg::tgt_abort;
		end
	end

	// registered decode outputs
	logic next_sel_valid;
	logic [7:0] next_cs;
	logic next_periph;
	logic next_internal;
	logic next_f0;
	logic next_f1;
	logic next_sram;
	logic next_rom;
	logic [31:0] next_offset;
	logic next_abort;

	always_comb begin
		next_sel_valid = req_valid;
		next_cs = (req_valid && target == addr_decode_pkg::tgt_external) ? ext_sel : 8'h00;
		next_periph = req_valid && target == addr_decode_pkg::tgt_periph;
		next_internal = req_valid && target == addr_decode_pkg::tgt_internal;
		next_f0 = next_internal && mem == addr_decode_pkg::mem_flash0;
		next_f1 = next_internal && mem == addr_decode_pkg::mem_flash1;
		next_sram = next_internal && mem == addr_decode_pkg::mem_sram;
		next_rom = next_internal && mem == addr_decode_pkg::mem_rom;
		next_offset = req_valid ? (is_internal ? offset
			: (req_addr & area_mask)) : 32'h0000_0000;
		next_abort = req_valid && target == addr_decode_pkg::tgt_abort;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sel_valid <= 1'b0;
			external_chip_select <= 8'h00;
			periph_sel <= 1'b0;
			internal_sel <= 1'b0;
			flash0_sel <= 1'b0;
			flash1_sel <= 1'b0;
			sram_sel <= 1'b0;
			rom_sel <= 1'b0;
			mem_offset <= 32'h0000_0000;
			abort <= 1'b0;
		end else begin
			sel_valid <= next_sel_valid;
			external_chip_select <= next_cs;
			periph_sel <= next_periph;
			internal_sel <= next_internal;
			flash0_sel <= next_f0;
			flash1_sel <= next_f1;
			sram_sel <= next_sram;
			rom_sel <= next_rom;
			mem_offset <= next_offset;
			abort <= next_abort;
		end
	end

	// checks
	sequence s_req_in(logic [3:0] a);
		req_valid && req_addr[31:28] == a;
	endsequence

	chk_unused_area_abort: assert property (@(posedge core_clk) disable iff (reset)
		req_valid && req_addr[31:28] > 4'h8 && req_addr[31:28] < 4'hF |=> abort && !periph_sel)
		else $error("unused area did not abort");
	chk_area_one_cs: assert property (@(posedge core_clk) disable iff (reset)
		s_req_in(4'h1) |=> external_chip_select == 8'h01)
		else $error("area one did not select chip zero");
	chk_area_eight_cs: assert property (@(posedge core_clk) disable iff (reset)
		s_req_in(4'h8) |=> external_chip_select == 8'h80)
		else $error("area eight did not select chip seven");
	chk_periph_area: assert property (@(posedge core_clk) disable iff (reset)
		s_req_in(4'hF) |=> periph_sel && !abort)
		else $error("peripheral area not routed");
	chk_rom_fixed: assert property (@(posedge core_clk) disable iff (reset)
		req_valid && req_addr[31:20] == 12'h003 |=> rom_sel)
		else $error("rom not at fixed base");
	chk_flash_fixed: assert property (@(posedge core_clk) disable iff (reset)
		req_valid && req_addr[31:20] == 12'h001 |=> flash0_sel || flash1_sel)
		else $error("flash not at fixed base");
	chk_zero_boot_rom: assert property (@(posedge core_clk) disable iff (reset)
		req_valid && req_addr[31:20] == 12'h000 && !remapped && !boot_select_nvm_bit
		|=> rom_sel)
		else $error("rom not aliased at zero");
	chk_zero_after_remap: assert property (@(posedge core_clk) disable iff (reset)
		req_valid && req_addr[31:20] == 12'h000 && remapped |=> sram_sel)
		else $error("sram not at zero after remap");
	chk_erase_clears_bit: assert property (@(posedge core_clk) disable iff (reset)
		erase |=> !boot_select_nvm_bit [*2] or (!boot_select_nvm_bit ##1 $rose(boot_select_nvm_bit)))
		else $error("erase did not clear boot select");
	chk_hole_abort: assert property (@(posedge core_clk) disable iff (reset)
		req_valid && req_addr[31:20] == 12'h004 |=> abort && !internal_sel)
		else $error("internal hole did not abort");
endmodule

// ===== dv/bus_master_model.sv
// bus master model: single-cycle requests plus the remap and nvm command pulses
// assumes the decoder takes a request at every rising edge of core_clk
`timescale 1ns/1ps
module bus_master_model (
	// clock
	input wire logic core_clk,
	// request
	output logic req_valid,
	output logic [31:0] req_addr,
	// controls
	output logic remap_cmd,
	output logic nvm_set_cmd,
	output logic nvm_clear_cmd,
	output logic erase
);
	initial begin
		req_valid = 1'b0;
		req_addr = 32'h0;
		{remap_cmd, nvm_set_cmd, nvm_clear_cmd, erase} = 4'h0;
	end
	task automatic drive(input logic [31:0] a);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_addr <= a;
	endtask
	// idle address flips each cycle so a stale value cannot pass for a decode
	task automatic idle();
		@(posedge core_clk);
		req_valid <= 1'b0;
		req_addr <= ~req_addr;
	endtask
	// the bit moves only through command pulses, never a plain write
	task automatic pulse(input logic [3:0] c);
		@(posedge core_clk);
		{remap_cmd, nvm_set_cmd, nvm_clear_cmd, erase} <= c;
		@(posedge core_clk);
		{remap_cmd, nvm_set_cmd, nvm_clear_cmd, erase} <= 4'h0;
	endtask
endmodule

// ===== dv/system_address_decoder_remap_bench.sv
// self-checking bench for the address decoder with remap and boot aliasing
// assumes the package is compiled first and the master model beside this file
`timescale 1ns/1ps
module system_address_decoder_remap_bench;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic req_valid, remap_cmd, nvm_set_cmd, nvm_clear_cmd, erase;
	logic [31:0] req_addr, mem_offset;
	logic [7:0] external_chip_select;
	logic sel_valid, periph_sel, internal_sel, flash0_sel, flash1_sel, sram_sel, rom_sel;
	logic abort, remapped, boot_select_nvm_bit;
	int failures = 0;
	int checked = 0;
	typedef struct {logic [31:0] addr; logic [15:0] sel; logic [31:0] off;} row_t;
	// sel: chip selects, periph, internal, flash0, flash1, sram, rom, abort, valid
	row_t rows [11] = '{'{32'h1000_0004, 16'h0101, 32'h0000_0004},
		'{32'h8ABC_DEF0, 16'h8001, 32'h0ABC_DEF0}, '{32'hF000_1234, 16'h0081, 32'h0000_1234},
		'{32'h9000_0000, 16'h0003, 32'hFFFF_FFFF}, '{32'hE000_0000, 16'h0003, 32'hFFFF_FFFF},
		'{32'h0010_0010, 16'h0061, 32'h0000_0010}, '{32'h0014_0000, 16'h0051, 32'h0000_0000},
		'{32'h0020_8004, 16'h0049, 32'h0000_0004}, '{32'h0030_0100, 16'h0045, 32'h0000_0100},
		'{32'h0000_0010, 16'h0045, 32'h0000_0010}, '{32'h0040_0000, 16'h0003, 32'hFFFF_FFFF}};
	always #50 core_clk = ~core_clk;
	bus_master_model i_master (.core_clk(core_clk), .req_valid(req_valid), .req_addr(req_addr),
		.remap_cmd(remap_cmd), .nvm_set_cmd(nvm_set_cmd), .nvm_clear_cmd(nvm_clear_cmd),
		.erase(erase));
	system_address_decoder_remap i_dut (.core_clk(core_clk), .reset(reset), .req_valid(req_valid),
		.req_addr(req_addr), .remap_cmd(remap_cmd), .nvm_set_cmd(nvm_set_cmd),
		.nvm_clear_cmd(nvm_clear_cmd), .erase(erase), .sel_valid(sel_valid),
		.external_chip_select(external_chip_select), .periph_sel(periph_sel),
		.internal_sel(internal_sel), .flash0_sel(flash0_sel), .flash1_sel(flash1_sel),
		.sram_sel(sram_sel), .rom_sel(rom_sel), .mem_offset(mem_offset), .abort(abort),
		.remapped(remapped), .boot_select_nvm_bit(boot_select_nvm_bit));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// all ones in the offset column means the offset is not looked at
	task automatic expect_sel(input logic [15:0] sel, input logic [31:0] off);
		chk("select", {16'h0, sel}, {16'h0, external_chip_select, periph_sel, internal_sel,
			flash0_sel, flash1_sel, sram_sel, rom_sel, abort, sel_valid});
		if (off !== 32'hFFFF_FFFF) chk("offset", off, mem_offset);
	endtask
	task automatic req(input logic [31:0] a, input logic [15:0] sel, input logic [31:0] off);
		i_master.drive(a);
		i_master.idle();
		#1 expect_sel(sel, off);
	endtask
	task automatic final_report();
		if (failures == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		final_report();
	end
	initial begin
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		#1 expect_sel(16'h0000, 32'h0);
		chk("boot bit", 32'h0, {31'h0, boot_select_nvm_bit});
		// rows go back to back: each result is read while the next request is taken
		i_master.drive(rows[0].addr);
		for (int i = 0; i < 11; i++) begin
			if (i < 10) i_master.drive(rows[i + 1].addr);
			else i_master.idle();
			#1 expect_sel(rows[i].sel, rows[i].off);
		end
		i_master.pulse(4'h4);
		#1 chk("boot bit", 32'h1, {31'h0, boot_select_nvm_bit});
		req(32'h0000_0020, 16'h0061, 32'h0000_0020);
		req(32'h0004_0000, 16'h0051, 32'h0000_0000);
		i_master.pulse(4'h6);
		#1 chk("boot bit", 32'h1, {31'h0, boot_select_nvm_bit});
		i_master.pulse(4'h5);
		#1 chk("boot bit", 32'h0, {31'h0, boot_select_nvm_bit});
		req(32'h0000_0040, 16'h0045, 32'h0000_0040);
		i_master.pulse(4'h4);
		req(32'h0020_0010, 16'h0049, 32'h0000_0010);
		i_master.pulse(4'h2);
		#1 chk("boot bit", 32'h0, {31'h0, boot_select_nvm_bit});
		i_master.pulse(4'h8);
		#1 chk("remapped", 32'h1, {31'h0, remapped});
		req(32'h0000_8010, 16'h0049, 32'h0000_0010);
		req(32'h0020_0010, 16'h0049, 32'h0000_0010);
		req(32'h0030_0000, 16'h0045, 32'h0000_0000);
		req(32'h0010_0000, 16'h0061, 32'h0000_0000);
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		#1 chk("remapped", 32'h0, {31'h0, remapped});
		req(32'h0000_0000, 16'h0045, 32'h0000_0000);
		final_report();
	end
endmodule
